// File: rtl/rcr_pkg.sv
// shared constants and carrier types for the repeater config register bank
package rcr_pkg;
  // register offsets
  localparam logic [7:0] STRAP_AND_LOAD_STATUS_OFS = 8'h00;
  localparam logic [7:0] IDLE_AND_LOSS_MONITOR_CHANNEL_CHOICE_CONTROL_OFS = 8'h01;
  localparam logic [7:0] SECONDARY_CONTROL_OFS = 8'h02;
  // reset values
  localparam logic [7:0] STRAP_AND_LOAD_STATUS_RST = 8'h00;
  localparam logic [7:0] IDLE_AND_LOSS_MONITOR_CHANNEL_CHOICE_CONTROL_RST = 8'h00;
  localparam logic [7:0] SECONDARY_CONTROL_RST = 8'h00;
  // field positions
  localparam int STRAP_LSB = 3;
  localparam int STRAP_MSB = 6;
  localparam int LOAD_BUSY_BIT = 2;
  localparam int IDLE_FIRST_BIT = 7;
  localparam int IDLE_SECOND_BIT = 6;
  localparam int LOSS_SEL_BIT = 2;
  // eeprom image layout
  localparam logic [7:0] IMG_FIRST_REG = 8'h03;
  localparam logic [7:0] IMG_LAST_REG = 8'h27;
  localparam logic [7:0] IMG_SHARED_BLOCK_ADDR = 8'h30;
  localparam logic [7:0] IMG_PTR_BASE = 8'h04;
  localparam int HDR_CRC_BIT = 7;
  localparam int HDR_MAP_BIT = 6;
  localparam int HDR_CNT_LSB = 0;
  localparam int HDR_CNT_MSB = 3;
  // timing counts
  // edges the loader waits after reset so both synchroniser stages hold pin levels
  localparam logic [1:0] SYNC_SETTLE = 2'h2;

  // register write from the serial slave front end
  typedef struct packed {
    logic       wrEn;
    logic [7:0] addr;
    logic [7:0] data;
  } rcr_wr_type;

  // one byte written by the eeprom loader into the register space
  typedef struct packed {
    logic       ldEn;
    logic [7:0] addr;
    logic [7:0] data;
  } rcr_ld_type;

  typedef enum logic [2:0] {
    LD_IDLE, LD_HDR, LD_PTR_LO, LD_PTR_HI, LD_BLOCK, LD_DONE
  } rcr_ld_state_type;
endpackage

// File: rtl/rcr_sync2.sv
// two-flop synchroniser for a bus of pin-level inputs
`timescale 1ns/1ps
module rcr_sync2 #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  initial begin
    if (WIDTH < 1) $error("rcr_sync2: WIDTH must be at least 1");
  end

  // first stage feeds only the second
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign sync_out = stage2_ff;
endmodule // rcr_sync2

// File: rtl/rcr_regs.sv
// first control and status registers plus eeprom image loader
`timescale 1ns/1ps
module rcr_regs #(
  parameter int STRAP_W = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // pins
  input wire logic [STRAP_W-1:0] addrStrap,
  input wire logic eepromPresent,
  input wire logic firstChannelLoss,
  input wire logic secondChannelLoss,
  // register port from serial slave front end
  input wire rcr_pkg::rcr_wr_type regWr,
  input wire logic [7:0] regRdAddr,
  output logic [7:0] regRdData,
  // eeprom read port: request byte, answer next cycle or later
  output logic eeReq,
  output logic [7:0] eeAddr,
  input wire logic eeAck,
  input wire logic [7:0] eeData,
  // controls to the data path
  output logic firstChannelTalk,
  output logic secondChannelTalk,
  output logic signalLossIndicator,
  output logic loadBusy,
  // loaded configuration byte for registers beyond this bank
  output rcr_pkg::rcr_ld_type cfgLoad
);
  initial begin
    if (STRAP_W != rcr_pkg::STRAP_MSB - rcr_pkg::STRAP_LSB + 1)
      $error("rcr_regs: STRAP_W must match the strap field");
  end

  logic [STRAP_W-1:0] strapSync;
  logic [2:0] pinSync;

  rcr_sync2 #(.WIDTH(STRAP_W)) u_strap_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(addrStrap),
    .sync_out(strapSync)
  );

  rcr_sync2 #(.WIDTH(3)) u_pin_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in({eepromPresent, firstChannelLoss, secondChannelLoss}),
    .sync_out(pinSync)
  );

  // ---------------- eeprom loader ----------------
  rcr_pkg::rcr_ld_state_type st_ff, nxt_st;
  logic [7:0] eeAddr_ff, nxt_eeAddr;
  logic eeReq_ff, nxt_eeReq;
  logic [7:0] regIdx_ff, nxt_regIdx;
  logic [7:0] blockPtr_ff, nxt_blockPtr;
  logic [7:0] hdr_ff, nxt_hdr;
  logic busy_ff, nxt_busy;
  logic [1:0] settle_ff, nxt_settle;
  rcr_pkg::rcr_ld_type ld_ff, nxt_ld;
  logic [3:0] devSel;
  logic [7:0] ptrAddr;

  // device index taken from all four strap bits
  assign devSel = strapSync;
  assign ptrAddr = rcr_pkg::IMG_PTR_BASE + {3'h0, devSel, 1'b0};

  always_comb begin
    nxt_st = st_ff;
    nxt_eeAddr = eeAddr_ff;
    nxt_eeReq = 1'b0;
    nxt_regIdx = regIdx_ff;
    nxt_blockPtr = blockPtr_ff;
    nxt_hdr = hdr_ff;
    nxt_busy = busy_ff;
    nxt_settle = settle_ff;
    nxt_ld = '0;
    case (st_ff)
      rcr_pkg::LD_IDLE: begin
        // synchronised pins read as reset zeros until both stages fill
        if (settle_ff != rcr_pkg::SYNC_SETTLE) begin
          nxt_settle = settle_ff + 2'h1;
        end else if (pinSync[2]) begin
          nxt_st = rcr_pkg::LD_HDR;
          nxt_eeAddr = 8'h00;
          nxt_eeReq = 1'b1;
          nxt_busy = 1'b1;
        end else begin
          nxt_st = rcr_pkg::LD_DONE;
          nxt_busy = 1'b0;
        end
      end
      rcr_pkg::LD_HDR: begin
        nxt_eeReq = !eeAck;
        if (eeAck) begin
          nxt_hdr = eeData;
          if (eeData[rcr_pkg::HDR_MAP_BIT] &&
              devSel <= eeData[rcr_pkg::HDR_CNT_MSB:rcr_pkg::HDR_CNT_LSB]) begin
            nxt_st = rcr_pkg::LD_PTR_LO;
            nxt_eeAddr = ptrAddr;
            nxt_eeReq = 1'b1;
          end else begin
            // no address map, or device index above the header count: single block right after the header
            nxt_st = rcr_pkg::LD_BLOCK;
            nxt_blockPtr = rcr_pkg::IMG_PTR_BASE - 8'h01;
            nxt_eeAddr = rcr_pkg::IMG_PTR_BASE - 8'h01;
            nxt_regIdx = rcr_pkg::IMG_FIRST_REG;
            nxt_eeReq = 1'b1;
          end
        end
      end
      rcr_pkg::LD_PTR_LO: begin
        nxt_eeReq = !eeAck;
        if (eeAck) begin
          // shared block: several pointers may name one address
          nxt_blockPtr = eeData;
          nxt_eeAddr = eeData;
          nxt_regIdx = rcr_pkg::IMG_FIRST_REG;
          nxt_st = rcr_pkg::LD_BLOCK;
          nxt_eeReq = 1'b1;
        end
      end
      rcr_pkg::LD_BLOCK: begin
        nxt_eeReq = !eeAck;
        if (eeAck) begin
          nxt_ld.ldEn = 1'b1;
          nxt_ld.addr = regIdx_ff;
          nxt_ld.data = eeData;
          if (regIdx_ff == rcr_pkg::IMG_LAST_REG) begin
            nxt_st = rcr_pkg::LD_DONE;
            nxt_busy = 1'b0;
            nxt_eeReq = 1'b0;
          end else begin
            nxt_regIdx = regIdx_ff + 8'h01;
            nxt_eeAddr = eeAddr_ff + 8'h01;
            nxt_eeReq = 1'b1;
          end
        end
      end
      rcr_pkg::LD_DONE: begin
        nxt_busy = 1'b0;
      end
      default: begin
        nxt_st = rcr_pkg::LD_DONE;
        nxt_busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= rcr_pkg::LD_IDLE;
      eeAddr_ff <= 8'h00;
      eeReq_ff <= 1'b0;
      regIdx_ff <= 8'h00;
      blockPtr_ff <= 8'h00;
      hdr_ff <= 8'h00;
      settle_ff <= 2'h0;
      // reads as loading until the first decision is made
      busy_ff <= 1'b1;
      ld_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      eeAddr_ff <= nxt_eeAddr;
      eeReq_ff <= nxt_eeReq;
      regIdx_ff <= nxt_regIdx;
      blockPtr_ff <= nxt_blockPtr;
      hdr_ff <= nxt_hdr;
      settle_ff <= nxt_settle;
      busy_ff <= nxt_busy;
      ld_ff <= nxt_ld;
    end
  end

  // ---------------- register bank ----------------
  logic [7:0] ctl1_ff, nxt_ctl1;
  logic [7:0] ctl2_ff, nxt_ctl2;
  logic [7:0] rd_ff, nxt_rd;
  logic loss_ff, nxt_loss;
  logic [1:0] talk_ff, nxt_talk;

  always_comb begin
    nxt_ctl1 = ctl1_ff;
    nxt_ctl2 = ctl2_ff;
    // loader writes first; a host write in the same cycle wins
    if (ld_ff.ldEn && ld_ff.addr == rcr_pkg::IDLE_AND_LOSS_MONITOR_CHANNEL_CHOICE_CONTROL_OFS)
      nxt_ctl1 = ld_ff.data;
    if (ld_ff.ldEn && ld_ff.addr == rcr_pkg::SECONDARY_CONTROL_OFS)
      nxt_ctl2 = ld_ff.data;
    if (regWr.wrEn && regWr.addr == rcr_pkg::IDLE_AND_LOSS_MONITOR_CHANNEL_CHOICE_CONTROL_OFS)
      nxt_ctl1 = regWr.data;
    if (regWr.wrEn && regWr.addr == rcr_pkg::SECONDARY_CONTROL_OFS)
      nxt_ctl2 = regWr.data;
    nxt_talk = {nxt_ctl1[rcr_pkg::IDLE_FIRST_BIT], nxt_ctl1[rcr_pkg::IDLE_SECOND_BIT]};
    nxt_loss = ctl1_ff[rcr_pkg::LOSS_SEL_BIT] ? pinSync[0] : pinSync[1];
    nxt_rd = 8'h00;
    case (regRdAddr)
      rcr_pkg::STRAP_AND_LOAD_STATUS_OFS: begin
        nxt_rd[rcr_pkg::STRAP_MSB:rcr_pkg::STRAP_LSB] = strapSync;
        nxt_rd[rcr_pkg::LOAD_BUSY_BIT] = busy_ff;
      end
      rcr_pkg::IDLE_AND_LOSS_MONITOR_CHANNEL_CHOICE_CONTROL_OFS: nxt_rd = ctl1_ff;
      rcr_pkg::SECONDARY_CONTROL_OFS: nxt_rd = ctl2_ff;
      default: nxt_rd = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl1_ff <= rcr_pkg::IDLE_AND_LOSS_MONITOR_CHANNEL_CHOICE_CONTROL_RST;
      ctl2_ff <= rcr_pkg::SECONDARY_CONTROL_RST;
      rd_ff <= rcr_pkg::STRAP_AND_LOAD_STATUS_RST;
      loss_ff <= 1'b0;
      talk_ff <= 2'h0;
    end else begin
      ctl1_ff <= nxt_ctl1;
      ctl2_ff <= nxt_ctl2;
      rd_ff <= nxt_rd;
      loss_ff <= nxt_loss;
      talk_ff <= nxt_talk;
    end
  end

  assign regRdData = rd_ff;
  assign eeReq = eeReq_ff;
  assign eeAddr = eeAddr_ff;
  assign firstChannelTalk = talk_ff[1];
  assign secondChannelTalk = talk_ff[0];
  assign signalLossIndicator = loss_ff;
  assign loadBusy = busy_ff;
  assign cfgLoad = ld_ff;
endmodule // rcr_regs

// File: tb/rcr_eeprom_model.sv
// behavioural configuration eeprom facing the image loader
`timescale 1ns/1ps
module rcr_eeprom_model (
  // clock
  input logic ref_clk,
  // byte request and answer
  input logic eeReq,
  input logic [7:0] eeAddr,
  output logic eeAck,
  output logic [7:0] eeData
);
  logic [7:0] mem [256];
  logic [1:0] waitCnt = 2'h0;
  initial begin
    eeAck = 1'b0;
    eeData = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
    // crc off, map on, count 3
    mem[0] = 8'h43;
    for (int i = 0; i < 4; i++) begin
      mem[4 + 2 * i] = (i == 1 || i == 2) ? 8'h30 : 8'h0b;
    end
    // offsets 3 to 39 in each block
    for (int k = 0; k < 37; k++) begin
      mem[11 + k] = 8'(7 * k);
      mem[48 + k] = 8'h80 | 8'(k);
    end
  end
  // slow or prompt by address; data bus inverts every cycle between answers
  always @(posedge ref_clk) begin
    eeAck <= 1'b0;
    eeData <= ~eeData;
    if (eeReq && !eeAck) begin
      waitCnt <= waitCnt + 2'h1;
      if (waitCnt == eeAddr[1:0]) begin
        eeAck <= 1'b1;
        eeData <= mem[eeAddr];
        waitCnt <= 2'h0;
      end
    end
  end
endmodule // rcr_eeprom_model

// File: tb/rcr_regs_monitor.sv
// assertion checker for the config register bank
`timescale 1ns/1ps
module rcr_regs_monitor (
  // clock and reset
  input logic ref_clk,
  input logic rst_n,
  // watched ports
  input logic firstChannelLoss,
  input logic secondChannelLoss,
  input rcr_pkg::rcr_wr_type regWr,
  input logic [7:0] regRdAddr,
  input logic [7:0] regRdData,
  input logic eeReq,
  input logic [7:0] eeAddr,
  input logic eeAck,
  input logic firstChannelTalk,
  input logic secondChannelTalk,
  input logic signalLossIndicator,
  input logic loadBusy,
  input rcr_pkg::rcr_ld_type cfgLoad
);
  logic sel_ff, nxt_sel, wr1, src;
  assign wr1 = regWr.wrEn && regWr.addr == rcr_pkg::IDLE_AND_LOSS_MONITOR_CHANNEL_CHOICE_CONTROL_OFS;
  assign src = sel_ff ? secondChannelLoss : firstChannelLoss;
  always_comb nxt_sel = wr1 ? regWr.data[rcr_pkg::LOSS_SEL_BIT] : sel_ff;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_ff <= 1'b0;
    end else begin
      sel_ff <= nxt_sel;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_talk_first:
    assert property (wr1 |-> ##2 firstChannelTalk == $past(regWr.data[7], 2)) else $error("talkA");
  chk_talk_second:
    assert property (wr1 |-> ##2 secondChannelTalk == $past(regWr.data[6],2)) else $error("talkB");
  chk_loss_high:
    assert property ((src && $stable(sel_ff))[*5] |-> signalLossIndicator) else $error("lossHi");
  chk_loss_low:
    assert property ((!src && $stable(sel_ff))[*5] |-> !signalLossIndicator) else $error("lossLo");
  chk_load_range:
    assert property (cfgLoad.ldEn |-> cfgLoad.addr inside {[8'h03:8'h27]} && $past(loadBusy))
      else $error("load byte out of place");
  chk_req_hold:
    assert property (eeReq && !eeAck |=> eeReq && $stable(eeAddr)) else $error("reqDrop");
  chk_idle_quiet:
    assert property (!loadBusy && !$past(loadBusy) |-> !eeReq && !cfgLoad.ldEn) else $error("idle");
  chk_status_busy:
    assert property ($past(regRdAddr) == 8'h00 && $past(rst_n) |-> regRdData[2] == $past(loadBusy))
      else $error("status bit");
  cover property (cfgLoad.ldEn && cfgLoad.addr == 8'h27);
  cover property (wr1 && regWr.data[2]);
  cover property (signalLossIndicator && sel_ff);
  cover property ($fell(loadBusy));
endmodule // rcr_regs_monitor
bind rcr_regs rcr_regs_monitor mon (.ref_clk, .rst_n, .firstChannelLoss, .secondChannelLoss,
  .regWr, .regRdAddr, .regRdData, .eeReq, .eeAddr, .eeAck, .firstChannelTalk,
  .secondChannelTalk, .signalLossIndicator, .loadBusy, .cfgLoad);

// File: tb/tb_rcr_regs.sv
// bench for the config register bank and image loader
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_rcr_regs;
  logic ref_clk = 1'b0, rst_n = 1'b0;
  logic [3:0] addrStrap = 4'h0;
  logic eepromPresent = 1'b1, firstChannelLoss = 1'b0, secondChannelLoss = 1'b0;
  rcr_pkg::rcr_wr_type regWr = '0;
  logic [7:0] regRdAddr = 8'h00;
  logic [7:0] regRdData, eeAddr, eeData, ldCnt, base, d, v;
  logic eeReq, eeAck, firstChannelTalk, secondChannelTalk, signalLossIndicator, loadBusy;
  rcr_pkg::rcr_ld_type cfgLoad;
  int n_fail = 0, num_checks = 0, seed = 51;
  always #12.5 ref_clk = ~ref_clk;
  rcr_regs dut (.ref_clk, .rst_n, .addrStrap, .eepromPresent, .firstChannelLoss,
    .secondChannelLoss, .regWr, .regRdAddr, .regRdData, .eeReq, .eeAddr, .eeAck, .eeData,
    .firstChannelTalk, .secondChannelTalk, .signalLossIndicator, .loadBusy, .cfgLoad);
  rcr_eeprom_model eeprom (.ref_clk, .eeReq, .eeAddr, .eeAck, .eeData);
  always @(posedge ref_clk) begin
    if (cfgLoad.ldEn === 1'b1) begin
      `CHK("ldAddr", 8'h03 + ldCnt, cfgLoad.addr)
      `CHK("ldData", eeprom.mem[base + ldCnt], cfgLoad.data)
      ldCnt <= ldCnt + 8'h01;
    end
  end
  // start of the strapped device's block, from image header and pointers
  function automatic logic [7:0] blkBase(input logic [3:0] s);
    logic [7:0] hdr;
    hdr = eeprom.mem[0];
    if (!hdr[6] || s > hdr[3:0]) begin
      return 8'h03;
    end
    return eeprom.mem[8'h04 + {3'h0, s, 1'b0}];
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic rdReg(input logic [7:0] a);
    @(posedge ref_clk);
    regRdAddr <= a;
    repeat (2) @(posedge ref_clk);
    #1 v = regRdData;
  endtask
  task automatic wrReg(input logic [7:0] a, input logic [7:0] dd);
    @(posedge ref_clk);
    regWr <= '{1'b1, a, dd};
    @(posedge ref_clk);
    regWr.wrEn <= 1'b0;
  endtask
  // reset with a strap, then follow the image load to its end
  task automatic boot(input logic [3:0] s, input logic pres);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    addrStrap <= s;
    eepromPresent <= pres;
    ldCnt = 8'h00;
    base = blkBase(s);
    repeat (3) @(posedge ref_clk);
    `CHK("busyRst", 1'b1, loadBusy)
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rdReg(8'h00);
    `CHK("strap", s, v[6:3])
    if (pres) `CHK("loading", 1'b1, v[2])
    for (int i = 0; i < 400 && loadBusy !== 1'b0; i++) @(posedge ref_clk);
    if (loadBusy !== 1'b0) begin
      n_fail++;
      results();
    end
    rdReg(8'h00);
    `CHK("done", 1'b0, v[2])
    `CHK("ldCnt", pres ? 8'h25 : 8'h00, ldCnt)
  endtask
  initial begin
    boot(4'h3, 1'b1);
    boot(4'h1, 1'b1);
    boot(4'h5, 1'b1);
    // address map off: pointers are ignored, block follows the header
    eeprom.mem[0] = 8'h03;
    boot(4'h2, 1'b1);
    eeprom.mem[0] = 8'h43;
    boot(4'hc, 1'b0);
    rdReg(8'h01);
    `CHK("ctlRst", 8'h00, v)
    wrReg(8'h00, 8'hff);
    rdReg(8'h00);
    `CHK("idRo", 8'h60, v)
    for (int i = 0; i < 12; i++) begin
      d = (i < 2) ? {8{i[0]}} & 8'hc4 : 8'($random(seed)) & 8'hc4;
      wrReg(8'h01, d);
      {firstChannelLoss, secondChannelLoss} <= 2'($random(seed));
      rdReg(8'h01);
      `CHK("ctl", d, v)
      `CHK("talk", d[7:6], {firstChannelTalk, secondChannelTalk})
      `CHK("loss", d[2] ? secondChannelLoss : firstChannelLoss, signalLossIndicator)
    end
    results();
  end
endmodule // tb_rcr_regs
